// [rtl/mecc_defs.svh]
`ifndef MECC_DEFS_SVH
`define MECC_DEFS_SVH

// register indices; byte address is four times the index
`define MECC_IDX_PCFG  16'hA00D
`define MECC_IDX_PADL  16'hA00E
`define MECC_IDX_PADH  16'hA00F
`define MECC_IDX_RCTL  16'hA010
`define MECC_IDX_DCFG  16'hA02D
`define MECC_IDX_DADL  16'hA02E
`define MECC_IDX_DADH  16'hA02F

// configuration field positions
`define MECC_BIT_EN    7
`define MECC_BIT_RSTEN 6
`define MECC_BIT_UIE   5
`define MECC_BIT_CIE   4
`define MECC_BIT_UF    1
`define MECC_BIT_CF    0

// reset values
`define MECC_DCFG_RST  8'h80
`define MECC_PCFG_RST  8'h80
`define MECC_EN_RST    1'b1

`endif

// [rtl/mecc_pkg.sv]
package mecc_pkg;

   typedef enum logic [1:0]
   {
      MECC_OKAY   = 2'b00,
      MECC_SLVERR = 2'b10
   } mecc_resp_t;

   typedef struct packed
   {
      logic        awrdy;
      logic        wrdy;
      logic        aw_full;
      logic        w_full;
      logic [15:0] aw_idx;
      logic [7:0]  w_data;
      logic        w_lane;
      logic        bvalid;
      mecc_resp_t  bresp;
      logic        arrdy;
      logic        rvalid;
      mecc_resp_t  rresp;
      logic [7:0]  rdata;
      logic        d_en;
      logic        d_uie;
      logic        d_cie;
      logic        d_uf;
      logic        d_cf;
      logic [15:0] d_addr;
      logic        c_uie;
      logic        c_cie;
      logic        c_uf;
      logic        c_cf;
      logic        c_rst_en;
      logic [15:0] c_addr;
      logic        ram_rd;
      logic [12:0] ram_raw;
      logic [15:0] ram_addr;
      logic [7:0]  ram_rdata;
      logic        ram_rvalid;
      logic [7:0]  fetch_data;
      logic        fetch_valid;
      logic        fctl_fail;
      logic        data_irq;
      logic        code_irq;
      logic        code_reset;
   } mecc_state_t;

endpackage : mecc_pkg

// [rtl/mecc_secded.sv]
`timescale 1ns/1ps
// extended hamming encoder and checker: HW hamming bits plus one parity
module mecc_secded #(
   parameter int DW = 8,
   parameter int HW = 4
) (
   input  wire logic [DW-1:0] i_data,
   input  wire logic [HW:0]   i_check,
   output logic      [DW-1:0] o_data,
   output logic      [HW:0]   o_gen,
   output logic               o_corr,
   output logic               o_uncorr
);

   // the j-th syndrome with at least two ones
   function automatic logic [HW-1:0] code(input int j);
      int k;
      logic [HW-1:0] r;
      k = 0;
      r = '0;
      for (int n = 3; n < 64; n++)
      begin
         if ((n & (n - 1)) != 0)
         begin
            if (k == j)
               r = n[HW-1:0];
            k++;
         end
      end
      return r;
   endfunction : code

   generate
      if ((2 ** HW) - HW - 1 < DW)
         $error("mecc_secded: too few hamming bits for data width");
   endgenerate

   logic [HW-1:0] ham;
   logic [HW-1:0] syn;
   logic          par;
   logic          hit;

   // generate check bits, then locate and flip a single failing bit
   always_comb
   begin
      ham = '0;
      for (int j = 0; j < DW; j++)
         ham = ham ^ ({HW{i_data[j]}} & code(j));
      o_gen = {(^i_data) ^ (^ham), ham};
      syn = ham ^ i_check[HW-1:0];
      par = (^i_data) ^ (^i_check);
      o_data = i_data;
      hit = 1'b0;
      o_corr = 1'b0;
      o_uncorr = 1'b0;
      if (par)
      begin
         for (int j = 0; j < DW; j++)
         begin
            if (syn == code(j))
            begin
               o_data[j] = ~i_data[j];
               hit = 1'b1;
            end
         end
         // a lone check or parity bit flip has a zero or one-hot syndrome
         if (hit || $countones(syn) <= 1)
            o_corr = 1'b1;
         else
            o_uncorr = 1'b1;
      end
      else if (syn != '0)
         o_uncorr = 1'b1;
   end

endmodule : mecc_secded

// [rtl/mecc_monitor.sv]
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "mecc_defs.svh"

// How it works
// - SRAM bytes stored with five check bits
// - single flips corrected, double flips detected
// - uncorrectable SRAM read latches address, interrupts
// - data uncorrectable flag bit 1, sticky
// - data correctable flag bit 0, sticky
// - enables bits 5 and 4 gate interrupts
// - bit 7 enables SRAM checking, resets on
// - data fault address frozen while flag set
// - flash low byte instruction, high byte check
// - each nibble has its own check bits
// - fetch corrects, sets bit 0 flag
// - fetch uncorrectable sets bit 1, irq/reset
// - program flags sticky until software clears
// - program fault address tracks latest error
// - reset-enable bit selects reset over interrupt for uncorrectable fetch errors
// - controller reads also set program flags
module mecc_monitor
   import mecc_pkg::*;
#(
   parameter int RAM_AW    = 11,
   parameter int RAM_DEPTH = 2048
) (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // axi4-lite slave
   input  wire logic [17:0] i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [17:0] i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // cpu data access to sram
   input  wire logic        i_ram_req,
   input  wire logic        i_ram_we,
   input  wire logic [15:0] i_ram_addr,
   input  wire logic [7:0]  i_ram_wdata,
   output logic [7:0]       o_ram_rdata,
   output logic             o_ram_rvalid,
   // program fetch from flash
   input  wire logic        i_fetch_valid,
   input  wire logic [15:0] i_fetch_addr,
   input  wire logic [15:0] i_fetch_word,
   output logic [7:0]       o_fetch_data,
   output logic             o_fetch_valid,
   // flash controller read command result
   input  wire logic        i_fctl_rd_valid,
   input  wire logic [15:0] i_fctl_addr,
   input  wire logic [15:0] i_fctl_word,
   output logic             o_fctl_ecc_fail,
   // events
   output logic             o_data_irq,
   output logic             o_code_irq,
   output logic             o_code_reset
);

   generate
      if (RAM_DEPTH != (2 ** RAM_AW) || RAM_AW > 16)
         $error("mecc_monitor: depth must be 2**RAM_AW, RAM_AW <= 16");
   endgenerate

   // all state except the sram array lives in one packed struct
   mecc_state_t s_r;
   mecc_state_t s_nxt;

   // data sram: one 13-bit word per byte, check bits on top
   logic [12:0] mem [RAM_DEPTH];

   // data path encode and check
   logic [4:0] wr_check;
   logic [7:0] rd_fixed;
   logic       rd_corr;
   logic       rd_uncorr;

   mecc_secded #(
      .DW (8),
      .HW (4)
   ) u_enc (
      .i_data   (i_ram_wdata),
      .i_check  (5'h00),
      .o_data   (),
      .o_gen    (wr_check),
      .o_corr   (),
      .o_uncorr ()
   );

   mecc_secded #(
      .DW (8),
      .HW (4)
   ) u_dec (
      .i_data   (s_r.ram_raw[7:0]),
      .i_check  (s_r.ram_raw[12:8]),
      .o_data   (rd_fixed),
      .o_gen    (),
      .o_corr   (rd_corr),
      .o_uncorr (rd_uncorr)
   );

   // program path: one checker per nibble for fetch and controller read
   logic [7:0] f_fixed;
   logic [1:0] f_corr;
   logic [1:0] f_uncorr;
   logic [1:0] k_corr;
   logic [1:0] k_uncorr;

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_nib
         mecc_secded #(
            .DW (4),
            .HW (3)
         ) u_fetch (
            .i_data   (i_fetch_word[4*g +: 4]),
            .i_check  (i_fetch_word[8+4*g +: 4]),
            .o_data   (f_fixed[4*g +: 4]),
            .o_gen    (),
            .o_corr   (f_corr[g]),
            .o_uncorr (f_uncorr[g])
         );
         // controller word is only checked, never corrected
         mecc_secded #(
            .DW (4),
            .HW (3)
         ) u_fctl (
            .i_data   (i_fctl_word[4*g +: 4]),
            .i_check  (i_fctl_word[8+4*g +: 4]),
            .o_data   (),
            .o_gen    (),
            .o_corr   (k_corr[g]),
            .o_uncorr (k_uncorr[g])
         );
      end
   endgenerate

   // with checking off the stored check bits are left as they were, so
   // bytes written meanwhile go stale once checking returns
   logic [4:0] wr_keep;
   assign wr_keep = s_r.d_en ? wr_check
                             : mem[i_ram_addr[RAM_AW-1:0]][12:8];

   // sram array: check bits written with every byte
   always_ff @(posedge i_clk)
   begin
      if (i_ram_req && i_ram_we)
         mem[i_ram_addr[RAM_AW-1:0]] <= {wr_keep, i_ram_wdata};
   end

   // combinational helpers of the next-state process
   logic       wr_go;
   logic [7:0] rd_val;
   logic       rd_hit;
   logic       d_ce;
   logic       d_ue;
   logic       p_ce;
   logic       p_ue;
   logic       fe_ue;
   logic       fe_any;
   logic       fk_any;

   // next state of bus slave, registers and data paths
   always_comb
   begin
      s_nxt = s_r;
      wr_go = s_r.aw_full && s_r.w_full && !s_r.bvalid;
      rd_val = 8'h00;
      rd_hit = 1'b1;

      // write address and data taken in either order
      if (s_r.awrdy && i_awvalid)
      begin
         s_nxt.aw_full = 1'b1;
         s_nxt.aw_idx = i_awaddr[17:2];
      end
      if (s_r.wrdy && i_wvalid)
      begin
         s_nxt.w_full = 1'b1;
         s_nxt.w_data = i_wdata[7:0];
         s_nxt.w_lane = i_wstrb[0];
      end
      // response released when taken
      if (s_r.bvalid && i_bready)
         s_nxt.bvalid = 1'b0;
      // register write applied once address and data are both held
      if (wr_go)
      begin
         s_nxt.aw_full = 1'b0;
         s_nxt.w_full = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = MECC_OKAY;
         unique case (s_r.aw_idx)
            `MECC_IDX_PCFG, `MECC_IDX_DCFG, `MECC_IDX_RCTL,
            `MECC_IDX_PADL, `MECC_IDX_PADH,
            `MECC_IDX_DADL, `MECC_IDX_DADH: s_nxt.bresp = MECC_OKAY;
            default: s_nxt.bresp = MECC_SLVERR;
         endcase
         if (s_r.w_lane)
         begin
            // flags: writing zero clears, writing one keeps
            if (s_r.aw_idx == `MECC_IDX_DCFG)
            begin
               s_nxt.d_en  = s_r.w_data[`MECC_BIT_EN];
               s_nxt.d_uie = s_r.w_data[`MECC_BIT_UIE];
               s_nxt.d_cie = s_r.w_data[`MECC_BIT_CIE];
               s_nxt.d_uf  = s_r.d_uf & s_r.w_data[`MECC_BIT_UF];
               s_nxt.d_cf  = s_r.d_cf & s_r.w_data[`MECC_BIT_CF];
            end
            if (s_r.aw_idx == `MECC_IDX_PCFG)
            begin
               s_nxt.c_uie = s_r.w_data[`MECC_BIT_UIE];
               s_nxt.c_cie = s_r.w_data[`MECC_BIT_CIE];
               s_nxt.c_uf  = s_r.c_uf & s_r.w_data[`MECC_BIT_UF];
               s_nxt.c_cf  = s_r.c_cf & s_r.w_data[`MECC_BIT_CF];
            end
            if (s_r.aw_idx == `MECC_IDX_RCTL)
               s_nxt.c_rst_en = s_r.w_data[`MECC_BIT_RSTEN];
         end
      end
      // readies drop while a taken half waits for its partner
      s_nxt.awrdy = !s_nxt.aw_full;
      s_nxt.wrdy = !s_nxt.w_full;

      // register read
      unique case (i_araddr[17:2])
         `MECC_IDX_PCFG:
            rd_val = `MECC_PCFG_RST | {2'b00, s_r.c_uie, s_r.c_cie,
                                       2'b00, s_r.c_uf, s_r.c_cf};
         `MECC_IDX_PADL: rd_val = s_r.c_addr[7:0];
         `MECC_IDX_PADH: rd_val = s_r.c_addr[15:8];
         `MECC_IDX_RCTL: rd_val = {1'b0, s_r.c_rst_en, 6'h00};
         `MECC_IDX_DCFG:
            rd_val = {s_r.d_en, 1'b0, s_r.d_uie, s_r.d_cie,
                      2'b00, s_r.d_uf, s_r.d_cf};
         `MECC_IDX_DADL: rd_val = s_r.d_addr[7:0];
         `MECC_IDX_DADH: rd_val = s_r.d_addr[15:8];
         default: rd_hit = 1'b0;
      endcase
      if (s_r.rvalid && i_rready)
      begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arrdy = 1'b1;
      end
      if (s_r.arrdy && i_arvalid)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.arrdy = 1'b0;
         s_nxt.rdata = rd_val;
         s_nxt.rresp = rd_hit ? MECC_OKAY : MECC_SLVERR;
      end
      // arready marks a free read slot, high from the edge after reset
      s_nxt.arrdy = !s_nxt.rvalid;

      // sram read: array word caught, checked one cycle later
      s_nxt.ram_rd = i_ram_req && !i_ram_we;
      s_nxt.ram_raw = mem[i_ram_addr[RAM_AW-1:0]];
      s_nxt.ram_addr = i_ram_addr;
      s_nxt.ram_rvalid = s_r.ram_rd;
      d_ce = s_r.ram_rd && s_r.d_en && rd_corr;
      d_ue = s_r.ram_rd && s_r.d_en && rd_uncorr;
      if (s_r.ram_rd)
         s_nxt.ram_rdata = s_r.d_en ? rd_fixed : s_r.ram_raw[7:0];
      // set wins over a clear in the same cycle
      s_nxt.d_uf = s_nxt.d_uf | d_ue;
      s_nxt.d_cf = s_nxt.d_cf | d_ce;
      if ((d_ce || d_ue) && !(s_r.d_uf || s_r.d_cf))
         s_nxt.d_addr = s_r.ram_addr;

      // program fetch checked alongside execution
      fe_ue = i_fetch_valid && (|f_uncorr);
      fe_any = i_fetch_valid && (|f_uncorr || |f_corr);
      fk_any = i_fctl_rd_valid && (|k_uncorr || |k_corr);
      p_ue = fe_ue || (i_fctl_rd_valid && (|k_uncorr));
      p_ce = (i_fetch_valid && !(|f_uncorr) && (|f_corr))
             || (i_fctl_rd_valid && !(|k_uncorr) && (|k_corr));
      s_nxt.fetch_valid = i_fetch_valid;
      if (i_fetch_valid)
         s_nxt.fetch_data = f_fixed;
      s_nxt.c_uf = s_nxt.c_uf | p_ue;
      s_nxt.c_cf = s_nxt.c_cf | p_ce;
      if (fe_any)
         s_nxt.c_addr = i_fetch_addr;
      else if (fk_any)
         s_nxt.c_addr = i_fctl_addr;
      s_nxt.fctl_fail = fk_any;
      s_nxt.code_reset = fe_ue && s_r.c_rst_en;

      // interrupt lines follow flags and enables
      s_nxt.data_irq = (s_nxt.d_uf && s_nxt.d_uie)
                       || (s_nxt.d_cf && s_nxt.d_cie);
      s_nxt.code_irq = (s_nxt.c_uf && s_nxt.c_uie && !s_nxt.c_rst_en)
                       || (s_nxt.c_cf && s_nxt.c_cie);
   end

   // state register
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         s_r <= '0;
         s_r.d_en <= `MECC_EN_RST;
      end
      else
         s_r <= s_nxt;
   end

   // bus slave outputs
   assign o_awready = s_r.awrdy;
   assign o_wready = s_r.wrdy;
   assign o_bresp = s_r.bresp;
   assign o_bvalid = s_r.bvalid;
   assign o_arready = s_r.arrdy;
   assign o_rdata = {24'h000000, s_r.rdata};
   assign o_rresp = s_r.rresp;
   assign o_rvalid = s_r.rvalid;

   // memory path outputs
   assign o_ram_rdata = s_r.ram_rdata;
   assign o_ram_rvalid = s_r.ram_rvalid;
   assign o_fetch_data = s_r.fetch_data;
   assign o_fetch_valid = s_r.fetch_valid;
   assign o_fctl_ecc_fail = s_r.fctl_fail;

   // event outputs
   assign o_data_irq = s_r.data_irq;
   assign o_code_irq = s_r.code_irq;
   assign o_code_reset = s_r.code_reset;

endmodule : mecc_monitor

// [sim/mecc_monitor_checker.sv]
`timescale 1ns/1ps
// port-level timing checks for the ecc monitor
module mecc_monitor_checker (
   input wire logic       i_clk,
   input wire logic       i_nrst,
   input wire logic       i_fetch_valid,
   input wire logic       o_fetch_valid,
   input wire logic       i_ram_req,
   input wire logic       i_ram_we,
   input wire logic       o_ram_rvalid,
   input wire logic       o_bvalid,
   input wire logic       i_bready,
   input wire logic [1:0] o_bresp,
   input wire logic       o_rvalid,
   input wire logic       i_rready,
   input wire logic [31:0] o_rdata,
   input wire logic       o_arready,
   input wire logic       o_code_reset,
   input wire logic       o_code_irq,
   input wire logic       o_data_irq,
   input wire logic       i_wvalid,
   input wire logic       i_fctl_rd_valid,
   input wire logic       o_fctl_ecc_fail
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // fetch answer comes exactly one cycle after each request
   fetch_answer_a: assert property (o_fetch_valid == $past(i_fetch_valid))
      else $error("fetch answer out of step");
   // sram read data arrives two cycles after the read
   ram_read_lat_a: assert property (i_ram_req && !i_ram_we |-> ##2 o_ram_rvalid)
      else $error("sram read answer late");
   // controller fail pulse only follows a controller read
   fctl_fail_a: assert property (o_fctl_ecc_fail |-> $past(i_fctl_rd_valid))
      else $error("controller fail without read");
   // reset request only follows a fetch
   code_reset_a: assert property (o_code_reset |-> $past(i_fetch_valid))
      else $error("reset request without fetch");
   // write response holds until taken
   bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   // read data holds until taken
   rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
   // no new read address while data is pending
   read_busy_a: assert property (o_rvalid |-> !o_arready)
      else $error("read address taken while busy");
   // program irq only drops after a register write
   irq_sticky_a: assert property ($fell(o_code_irq) |-> $past(i_wvalid, 2) || $past(i_wvalid, 3))
      else $error("program irq dropped by itself");
   // data irq rises only with an sram answer or a register write
   data_irq_rise_a: assert property ($rose(o_data_irq)
      |-> o_ram_rvalid || $past(i_wvalid, 2))
      else $error("data irq raised without cause");
   // data irq drops only after a register write
   data_irq_hold_a: assert property ($fell(o_data_irq)
      |-> $past(i_wvalid, 2))
      else $error("data irq dropped by itself");
endmodule : mecc_monitor_checker

bind mecc_monitor mecc_monitor_checker chk (.*);

// [sim/mecc_flash_model.sv]
`timescale 1ns/1ps
// flash seen by the fetch path: low byte data, high byte checks
module mecc_flash_model (
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_mask,
   output logic      [15:0] o_word
);
   // per nibble hamming check with overall parity on top
   function automatic logic [3:0] enc(input logic [3:0] d);
      logic [2:0] h;
      h[0] = d[0] ^ d[1] ^ d[3];
      h[1] = d[0] ^ d[2] ^ d[3];
      h[2] = d[1] ^ d[2] ^ d[3];
      return {^{d, h}, h};
   endfunction : enc
   logic [7:0] dat;
   // contents follow the low address byte, so they repeat every 256 locations
   assign dat = i_addr[7:0] ^ 8'h5A;
   // bit faults are injected through the mask
   assign o_word = {enc(dat[7:4]), enc(dat[3:0]), dat} ^ i_mask;
endmodule : mecc_flash_model

// [sim/mecc_monitor_tb_top.sv]
`timescale 1ns/1ps
`include "mecc_defs.svh"
module mecc_monitor_tb_top
   import mecc_pkg::*;
;
   logic        i_clk = 0, i_nrst = 0, i_awvalid = 0, i_wvalid = 0;
   logic        i_bready = 0, i_arvalid = 0, i_rready = 0;
   logic [17:0] i_awaddr = '0, i_araddr = '0;
   logic [31:0] i_wdata = '0, o_rdata;
   logic [3:0]  i_wstrb = '0;
   logic        i_ram_req = 0, i_ram_we = 0;
   logic        i_fetch_valid = 0, i_fctl_rd_valid = 0;
   logic [15:0] i_ram_addr = '0, ma = '0, msk = '0;
   logic [7:0]  i_ram_wdata = '0, o_ram_rdata, o_fetch_data;
   wire  [15:0] fw;
   wire  [15:0] i_fetch_addr = ma, i_fctl_addr = ma;
   wire  [15:0] i_fetch_word = fw, i_fctl_word = fw;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0]  o_bresp, o_rresp;
   logic        o_ram_rvalid, o_fetch_valid, o_fctl_ecc_fail;
   logic        o_data_irq, o_code_irq, o_code_reset;
   int          n_errors = 0, tests_run = 0, cyc = 0, stall = 0;

   always #4 i_clk = ~i_clk;
   mecc_monitor dut (.*);
   mecc_flash_model fm (.i_addr(ma), .i_mask(msk), .o_word(fw));

   task print_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] s, e);
      tests_run++;
      if (s !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
      end
   endtask : chk

   // axi write; a stall delays bready
   task automatic wr(input logic [15:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      @(posedge i_clk);
      i_awaddr <= {a, 2'b00};
      i_wdata <= {24'h0, d};
      i_wstrb <= 4'hF;
      {i_awvalid, i_wvalid} <= 2'b11;
      i_bready <= (stall == 0);
      fork
         begin do @(posedge i_clk); while (!o_awready); i_awvalid <= 0; end
         begin do @(posedge i_clk); while (!o_wready); i_wvalid <= 0; end
      join
      repeat (stall) @(posedge i_clk);
      i_bready <= 1;
      do @(posedge i_clk); while (!o_bvalid);
      i_bready <= 0;
      chk(o_bresp, r);
   endtask : wr

   // axi read; a stall delays rready
   task automatic rd(input logic [15:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      @(posedge i_clk);
      i_araddr <= {a, 2'b00};
      i_arvalid <= 1;
      i_rready <= (stall == 0);
      do @(posedge i_clk); while (!o_arready);
      i_arvalid <= 0;
      repeat (stall) @(posedge i_clk);
      i_rready <= 1;
      do @(posedge i_clk); while (!o_rvalid);
      i_rready <= 0;
      chk(o_rdata, {24'h0, d});
      chk(o_rresp, r);
   endtask : rd

   // fetch from the flash model with fault mask m
   task automatic fetch(input logic [15:0] a, m, input logic ck, rs);
      @(posedge i_clk);
      ma <= a;
      msk <= m;
      i_fetch_valid <= 1;
      @(posedge i_clk);
      i_fetch_valid <= 0;
      @(posedge i_clk);
      chk(o_fetch_valid, 1);
      if (ck)
         chk(o_fetch_data, a[7:0] ^ 8'h5A);
      chk(o_code_reset, rs);
   endtask : fetch

   // flash controller read result
   task automatic ctl(input logic [15:0] a, m, input logic f);
      @(posedge i_clk);
      ma <= a;
      msk <= m;
      i_fctl_rd_valid <= 1;
      @(posedge i_clk);
      i_fctl_rd_valid <= 0;
      @(posedge i_clk);
      chk(o_fctl_ecc_fail, f);
   endtask : ctl

   // sram access; reads are checked against d
   task automatic ram(input logic we, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge i_clk);
      {i_ram_req, i_ram_we, i_ram_addr, i_ram_wdata} <= {1'b1, we, a, d};
      @(posedge i_clk);
      i_ram_req <= 0;
      if (!we)
      begin
         repeat (2) @(posedge i_clk);
         chk(o_ram_rvalid, 1);
         chk(o_ram_rdata, d);
      end
   endtask : ram

   task t_regs;
      rd(`MECC_IDX_PCFG, 8'h80, 2'b00);
      rd(`MECC_IDX_PADL, 8'h00, 2'b00);
      rd(`MECC_IDX_DCFG, 8'h80, 2'b00);
      rd(`MECC_IDX_DADH, 8'h00, 2'b00);
      rd(`MECC_IDX_RCTL, 8'h00, 2'b00);
      wr(`MECC_IDX_DADL, 8'hFF, 2'b00);
      stall = 3;
      rd(`MECC_IDX_DADL, 8'h00, 2'b00);
      wr(16'hA011, 8'hFF, 2'b10);
      stall = 0;
      rd(16'hA011, 8'h00, 2'b10);
      $display("test regs done");
   endtask : t_regs

   task t_ram;
      ram(1, 16'h0005, 8'hA5);
      ram(1, 16'h07FF, 8'h3C);
      ram(0, 16'h0005, 8'hA5);
      ram(0, 16'h07FF, 8'h3C);
      wr(`MECC_IDX_DCFG, 8'hB0, 2'b00);
      rd(`MECC_IDX_DCFG, 8'hB0, 2'b00);
      chk(o_data_irq, 0);
      wr(`MECC_IDX_DCFG, 8'h00, 2'b00);
      ram(1, 16'h0007, 8'h81);
      ram(0, 16'h0007, 8'h81);
      wr(`MECC_IDX_DCFG, 8'h80, 2'b00);
      ram(1, 16'h0007, 8'h42);
      ram(0, 16'h0007, 8'h42);
      rd(`MECC_IDX_DADL, 8'h00, 2'b00);
      $display("test ram done");
   endtask : t_ram

   // plants a faulty byte by rewriting it with checking off
   task automatic plant(input logic [15:0] a, input logic [7:0] d, f);
      ram(1, a, d);
      wr(`MECC_IDX_DCFG, 8'h30, 2'b00);
      ram(1, a, d ^ f);
      wr(`MECC_IDX_DCFG, 8'hB0, 2'b00);
   endtask : plant

   task t_dram;
      plant(16'h0123, 8'h96, 8'h04);
      plant(16'h0456, 8'h5A, 8'h21);
      ram(0, 16'h0123, 8'h96);
      chk(o_data_irq, 1);
      rd(`MECC_IDX_DCFG, 8'hB1, 2'b00);
      rd(`MECC_IDX_DADH, 8'h01, 2'b00);
      // an uncorrectable byte comes back as stored
      ram(0, 16'h0456, 8'h7B);
      rd(`MECC_IDX_DCFG, 8'hB3, 2'b00);
      rd(`MECC_IDX_DADL, 8'h23, 2'b00);
      ram(1, 16'h0123, 8'h96);
      wr(`MECC_IDX_DCFG, 8'hB0, 2'b00);
      chk(o_data_irq, 0);
      ram(0, 16'h0456, 8'h7B);
      chk(o_data_irq, 1);
      rd(`MECC_IDX_DADL, 8'h56, 2'b00);
      wr(`MECC_IDX_DCFG, 8'h80, 2'b00);
      ram(0, 16'h0456, 8'h7B);
      rd(`MECC_IDX_DCFG, 8'h82, 2'b00);
      chk(o_data_irq, 0);
      wr(`MECC_IDX_DCFG, 8'h80, 2'b00);
      ram(0, 16'h0123, 8'h96);
      rd(`MECC_IDX_DCFG, 8'h80, 2'b00);
      $display("test dram done");
   endtask : t_dram

   task t_fetch;
      for (int b = 0; b < 16; b++)
         fetch(16'h0100 + b, 16'h0001 << b, 1, 0);
      rd(`MECC_IDX_PCFG, 8'h81, 2'b00);
      rd(`MECC_IDX_PADL, 8'h0F, 2'b00);
      fetch(16'h0222, 16'h0011, 1, 0);
      rd(`MECC_IDX_PADH, 8'h02, 2'b00);
      wr(`MECC_IDX_PCFG, 8'h80, 2'b00);
      fetch(16'h0333, 16'h0000, 1, 0);
      rd(`MECC_IDX_PCFG, 8'h80, 2'b00);
      rd(`MECC_IDX_PADL, 8'h22, 2'b00);
      $display("test fetch done");
   endtask : t_fetch

   task t_irq;
      wr(`MECC_IDX_PCFG, 8'h90, 2'b00);
      chk(o_code_irq, 0);
      fetch(16'h0010, 16'h0004, 1, 0);
      rd(`MECC_IDX_PCFG, 8'h91, 2'b00);
      chk(o_code_irq, 1);
      wr(`MECC_IDX_PCFG, 8'hA0, 2'b00);
      rd(`MECC_IDX_PCFG, 8'hA0, 2'b00);
      chk(o_code_irq, 0);
      fetch(16'h0444, 16'h0013, 0, 0);
      rd(`MECC_IDX_PCFG, 8'hA2, 2'b00);
      chk(o_code_irq, 1);
      wr(`MECC_IDX_PCFG, 8'hA0, 2'b00);
      wr(`MECC_IDX_RCTL, 8'h40, 2'b00);
      rd(`MECC_IDX_RCTL, 8'h40, 2'b00);
      fetch(16'h0555, 16'h0300, 0, 1);
      rd(`MECC_IDX_PCFG, 8'hA2, 2'b00);
      chk(o_code_irq, 0);
      rd(`MECC_IDX_PADL, 8'h55, 2'b00);
      wr(`MECC_IDX_RCTL, 8'h00, 2'b00);
      wr(`MECC_IDX_PCFG, 8'h80, 2'b00);
      $display("test irq done");
   endtask : t_irq

   task t_fctl;
      ctl(16'h0666, 16'h0000, 0);
      ctl(16'h0777, 16'h0020, 1);
      rd(`MECC_IDX_PCFG, 8'h81, 2'b00);
      rd(`MECC_IDX_PADH, 8'h07, 2'b00);
      ctl(16'h0888, 16'h0030, 1);
      rd(`MECC_IDX_PCFG, 8'h83, 2'b00);
      $display("test fctl done");
   endtask : t_fctl

   // cuts a hung run short
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         print_verdict;
      end
   end

   // reset, then the scenarios in turn
   initial
   begin
      repeat (3) @(posedge i_clk);
      i_nrst <= 1;
      t_regs;
      t_ram;
      t_dram;
      t_fetch;
      t_irq;
      t_fctl;
      print_verdict;
   end
endmodule : mecc_monitor_tb_top
